// >>> adcsc_pkg.sv
// package: register map, reset values and timing constants of the converter control
package adcsc_pkg;
	localparam logic [7:0] ADC_MODE_ADDR = 8'hbc;
	localparam logic [7:0] ADC_RESULT_ADDR = 8'hbd;
	localparam logic [7:0] ADC_START_ADDR = 8'hbe;
	localparam logic [7:0] ADC_IRQ_STATUS_ADDR = 8'hbf;
	localparam logic [7:0] ADC_IRQ_MASK_ADDR = 8'hc0;
	localparam logic [7:0] ADC_MODE_RESET = 8'h78;
	localparam logic [7:0] ADC_START_RESET = 8'h7f;
	localparam int PERIOD_BIT = 7;
	localparam int START_BIT = 7;
	localparam logic [2:0] MODE_UNUSED_ONES = 3'h7;
	localparam logic [6:0] START_UNUSED_ONES = 7'h7f;
	localparam logic [7:0] SLOW_PERIOD_CYCLES = 8'd64;
	localparam logic [7:0] FAST_PERIOD_CYCLES = 8'd31;
	localparam int CHANNELS = 8;
	typedef enum logic [1:0] {
		ADCSC_IDLE,
		ADCSC_CONV
	} adcsc_state_e;
endpackage : adcsc_pkg

// >>> adcsc_period_counter.sv
// module: conversion period down-counter
`timescale 1ns/100ps
module adcsc_period_counter #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// control
	input wire logic load_i,
	input wire logic clear_i,
	input wire logic [WIDTH-1:0] count_i,
	// status
	output logic done_o
);
	logic [WIDTH-1:0] remaining;

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			remaining <= '0;
		end else if (clear_i) begin
			remaining <= '0;
		end else if (load_i) begin
			remaining <= count_i;
		end else if (remaining != '0) begin
			remaining <= remaining - 1'b1;
		end
	end

	assign done_o = (remaining == {{(WIDTH-1){1'b0}}, 1'b1}) && !load_i && !clear_i;
endmodule : adcsc_period_counter

// >>> adcsc_top.sv
// module: eight-channel converter sequence control with register port
//------------------------------------------------------------------
// Behaviour
// - period bit picks conversion length: 0 gives 64 cycles, 1 gives 31.
// - three-bit channel field routes one of eight analog inputs to converter.
// - eight-bit result held in a read-only register, undefined after reset.
// - writing one to the start flag begins conversion on chosen channel.
// - start flag reads one while a conversion runs.
// - start flag reads zero when idle and clears itself on completion.
// - writing zero to start flag during conversion aborts it at once.
//------------------------------------------------------------------
`timescale 1ns/100ps
module adcsc_top #(
	parameter int DATA_W = 8
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// converter core
	output logic [adcsc_pkg::CHANNELS-1:0] analog_input_pin_sel_o,
	output logic conv_sample_o,
	input wire logic [DATA_W-1:0] conv_data_i,
	// interrupt
	output logic irq_o
);
	//------------------------------------------------------------------
	// registers
	//------------------------------------------------------------------
	logic conversion_period_select;
	logic [2:0] channel_select;
	logic [DATA_W-1:0] adc_result;
	adcsc_pkg::adcsc_state_e state;
	logic conversion_start_flag;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic period_done;
	logic start_req;
	logic abort_req;
	logic [7:0] period_cycles;

	assign start_req = wr_i && addr_i == adcsc_pkg::ADC_START_ADDR
		&& wdata_i[adcsc_pkg::START_BIT];
	assign abort_req = wr_i && addr_i == adcsc_pkg::ADC_START_ADDR
		&& !wdata_i[adcsc_pkg::START_BIT];
	assign conversion_start_flag = (state == adcsc_pkg::ADCSC_CONV);

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			conversion_period_select <= adcsc_pkg::ADC_MODE_RESET[7];
			channel_select <= adcsc_pkg::ADC_MODE_RESET[2:0];
		end else if (wr_i && addr_i == adcsc_pkg::ADC_MODE_ADDR) begin
			conversion_period_select <= wdata_i[adcsc_pkg::PERIOD_BIT];
			channel_select <= wdata_i[2:0];
		end
	end

	//------------------------------------------------------------------
	// conversion sequence
	//------------------------------------------------------------------
	assign period_cycles = conversion_period_select ?
		adcsc_pkg::FAST_PERIOD_CYCLES : adcsc_pkg::SLOW_PERIOD_CYCLES;

	adcsc_period_counter #(
		.WIDTH(8)
	) u_period (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.load_i(start_req && state == adcsc_pkg::ADCSC_IDLE),
		.clear_i(abort_req),
		.count_i(period_cycles),
		.done_o(period_done)
	);

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= adcsc_pkg::ADCSC_IDLE;
		end else begin
			case (state)
				adcsc_pkg::ADCSC_IDLE: begin
					if (start_req) begin
						state <= adcsc_pkg::ADCSC_CONV;
					end
				end
				adcsc_pkg::ADCSC_CONV: begin
					if (abort_req) begin
						state <= adcsc_pkg::ADCSC_IDLE;
					end else if (period_done) begin
						state <= adcsc_pkg::ADCSC_IDLE;
					end
				end
				default: begin
					state <= adcsc_pkg::ADCSC_IDLE;
				end
			endcase
		end
	end

	always_comb begin
		analog_input_pin_sel_o = '0;
		analog_input_pin_sel_o[channel_select] = 1'b1;
	end
	assign conv_sample_o = conversion_start_flag;

	// result loads only on completion; no reset value
	always_ff @(posedge sys_clk_i) begin
		if (state == adcsc_pkg::ADCSC_CONV && period_done && !abort_req) begin
			adc_result <= conv_data_i;
		end
	end

	//------------------------------------------------------------------
	// interrupt: bit0 completion, bit1 abort
	//------------------------------------------------------------------
	logic [1:0] irq_event;
	logic clr_status;
	assign irq_event[0] = state == adcsc_pkg::ADCSC_CONV && period_done && !abort_req;
	assign irq_event[1] = state == adcsc_pkg::ADCSC_CONV && abort_req;
	assign clr_status = wr_i && addr_i == adcsc_pkg::ADC_IRQ_STATUS_ADDR;

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_status <= 2'h0;
		end else begin
			irq_status <= (irq_status & ~(clr_status ? wdata_i[1:0] : 2'h0))
				| irq_event;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_mask <= 2'h0;
		end else if (wr_i && addr_i == adcsc_pkg::ADC_IRQ_MASK_ADDR) begin
			irq_mask <= wdata_i[1:0];
		end
	end

	assign irq_o = |(irq_status & irq_mask);

	//------------------------------------------------------------------
	// read port
	//------------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				adcsc_pkg::ADC_MODE_ADDR: begin
					rdata_o <= {conversion_period_select,
						adcsc_pkg::MODE_UNUSED_ONES, 1'b1, channel_select};
				end
				adcsc_pkg::ADC_RESULT_ADDR: begin
					rdata_o <= adc_result;
				end
				adcsc_pkg::ADC_START_ADDR: begin
					rdata_o <= {conversion_start_flag,
						adcsc_pkg::START_UNUSED_ONES};
				end
				adcsc_pkg::ADC_IRQ_STATUS_ADDR: begin
					rdata_o <= {6'h00, irq_status};
				end
				adcsc_pkg::ADC_IRQ_MASK_ADDR: begin
					rdata_o <= {6'h00, irq_mask};
				end
				default: begin
					rdata_o <= 8'h00;
				end
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	//------------------------------------------------------------------
	// checks
	//------------------------------------------------------------------
	// helper: cycles spent converting and the period taken at start
	logic [7:0] conv_cycles;
	logic conv_fast;

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			conv_cycles <= 8'h00;
		end else if (!conversion_start_flag) begin
			conv_cycles <= 8'h00;
		end else begin
			conv_cycles <= conv_cycles + 8'h01;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			conv_fast <= 1'b0;
		end else if (start_req && state == adcsc_pkg::ADCSC_IDLE) begin
			conv_fast <= conversion_period_select;
		end
	end

	sequence s_slow_last;
		conversion_start_flag && !conv_fast
			&& conv_cycles == adcsc_pkg::SLOW_PERIOD_CYCLES - 8'h01;
	endsequence
	sequence s_fast_last;
		conversion_start_flag && conv_fast
			&& conv_cycles == adcsc_pkg::FAST_PERIOD_CYCLES - 8'h01;
	endsequence

	property p_slow_period;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_slow_last |=> !conversion_start_flag;
	endproperty
	a_slow_period: assert property (p_slow_period) else $error("slow period wrong");

	property p_fast_end;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_fast_last |=> !conversion_start_flag;
	endproperty
	a_fast_end: assert property (p_fast_end) else $error("fast period too long");

	property p_no_early_end;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		conversion_start_flag && !abort_req
			&& conv_cycles + 8'h01 != (conv_fast ?
			adcsc_pkg::FAST_PERIOD_CYCLES : adcsc_pkg::SLOW_PERIOD_CYCLES)
			|=> conversion_start_flag;
	endproperty
	a_no_early_end: assert property (p_no_early_end) else $error("period too short");

	property p_channel;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		analog_input_pin_sel_o == (8'h01 << channel_select);
	endproperty
	a_channel: assert property (p_channel) else $error("channel select wrong");

	property p_start;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		start_req && state == adcsc_pkg::ADCSC_IDLE |=> conversion_start_flag;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");

	property p_flag_read;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		rd_i && addr_i == adcsc_pkg::ADC_START_ADDR |=>
			rdata_o[7] == $past(conversion_start_flag);
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("start flag read wrong");

	property p_self_clear;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		conversion_start_flag |-> conv_cycles < adcsc_pkg::SLOW_PERIOD_CYCLES;
	endproperty
	a_self_clear: assert property (p_self_clear) else $error("flag never clears");

	property p_abort;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		conversion_start_flag && abort_req |=> !conversion_start_flag
			&& $stable(adc_result);
	endproperty
	a_abort: assert property (p_abort) else $error("abort not immediate");

	property p_load;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		irq_event[0] |=> !conversion_start_flag
			&& adc_result == $past(conv_data_i);
	endproperty
	a_load: assert property (p_load) else $error("result not loaded");

	property p_irq;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		irq_event[0] |=> irq_status[0];
	endproperty
	a_irq: assert property (p_irq) else $error("completion status lost");
endmodule : adcsc_top

// >>> adcsc_core_model.sv
// converter core model returning channel-coded samples
`timescale 1ns/100ps
module adcsc_core_model (
	// clock
	input wire logic sys_clk_i,
	// converter side
	input wire logic [7:0] sel_i,
	input wire logic sample_i,
	output logic [7:0] data_o
);
	logic [7:0] churn = 8'h00;
	always @(posedge sys_clk_i) begin
		churn <= churn + 8'h01;
	end
	// value valid only while sampling
	assign data_o = sample_i ? (sel_i ^ 8'ha5) : churn;
endmodule : adcsc_core_model

// >>> tb_top.sv
// testbench for the converter sequence control
`timescale 1ns/100ps
module tb_top;
	logic sys_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] rdata_o;
	logic [7:0] sel;
	logic [7:0] data;
	logic conv_sample_o;
	logic irq_o;
	logic [7:0] rv;
	int n_fail = 0;
	int checks = 0;
	int n;
	always #5 sys_clk_i = ~sys_clk_i;
	adcsc_top dut (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rdata_o(rdata_o),
		.analog_input_pin_sel_o(sel),
		.conv_sample_o(conv_sample_o),
		.conv_data_i(data),
		.irq_o(irq_o)
	);
	adcsc_core_model core (
		.sys_clk_i(sys_clk_i),
		.sel_i(sel),
		.sample_i(conv_sample_o),
		.data_o(data)
	);
	//--------------------------------
	// bus tasks
	//--------------------------------
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1;
		rv = rdata_o;
	endtask : rd
	task run();
		n = 0;
		while (conv_sample_o === 1'b1 && n < 100) begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
	endtask : run
	task end_sim();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim
	//--------------------------------
	// tests
	//--------------------------------
	initial begin
		repeat (20) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		#1;
		chk("sel", 8'h01, sel);
		rd(adcsc_pkg::ADC_MODE_ADDR);
		chk("mode", adcsc_pkg::ADC_MODE_RESET, rv);
		rd(adcsc_pkg::ADC_START_ADDR);
		chk("start", 8'h7f, rv);
		rd(8'hc1);
		chk("unmapped", 8'h00, rv);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			wr(adcsc_pkg::ADC_MODE_ADDR, {i[0], 4'h0, i[2:0]});
			chk("sel", 8'h01 << i, sel);
			rd(adcsc_pkg::ADC_MODE_ADDR);
			chk("mode", {i[0], 4'hf, i[2:0]}, rv);
			wr(adcsc_pkg::ADC_START_ADDR, 8'h80);
			run();
			chk("period", i[0] ? 8'd31 : 8'd64, n[7:0]);
			rd(adcsc_pkg::ADC_RESULT_ADDR);
			chk("result", (8'h01 << i) ^ 8'ha5, rv);
			rd(adcsc_pkg::ADC_START_ADDR);
			chk("flag", 8'h7f, rv);
		end
		$display("test channels done");
		wr(adcsc_pkg::ADC_START_ADDR, 8'h80);
		rd(adcsc_pkg::ADC_START_ADDR);
		chk("flag", 8'hff, rv);
		wr(adcsc_pkg::ADC_START_ADDR, 8'h00);
		chk("sample", 8'h00, {7'h00, conv_sample_o});
		wr(adcsc_pkg::ADC_RESULT_ADDR, 8'h3c);
		rd(adcsc_pkg::ADC_RESULT_ADDR);
		chk("result", 8'h25, rv);
		$display("test abort done");
		chk("irq", 8'h00, {7'h00, irq_o});
		rd(adcsc_pkg::ADC_IRQ_STATUS_ADDR);
		chk("status", 8'h03, rv & 8'h03);
		wr(adcsc_pkg::ADC_IRQ_MASK_ADDR, 8'h03);
		chk("irq", 8'h01, {7'h00, irq_o});
		wr(adcsc_pkg::ADC_IRQ_STATUS_ADDR, 8'h03);
		chk("irq", 8'h00, {7'h00, irq_o});
		wr(adcsc_pkg::ADC_IRQ_MASK_ADDR, 8'h02);
		wr(adcsc_pkg::ADC_START_ADDR, 8'h80);
		run();
		chk("irq", 8'h00, {7'h00, irq_o});
		wr(adcsc_pkg::ADC_IRQ_MASK_ADDR, 8'h01);
		chk("irq", 8'h01, {7'h00, irq_o});
		wr(adcsc_pkg::ADC_IRQ_STATUS_ADDR, 8'h01);
		chk("irq", 8'h00, {7'h00, irq_o});
		$display("test irq done");
		end_sim();
	end
	initial begin
		#50000;
		n_fail++;
		end_sim();
	end
endmodule : tb_top
